// [common/rfp_pkg.sv]
/*
 * Constants and types for the ram/flash partition register block.
 * Assumes a single 100 MHz clock, synchronous active-high reset and a
 * plain strobe register port with read data one cycle after the strobe.
 */
// Summary of operation
// - user data base bits 31-16 read zero
// - six-bit field 15-10 sets user data start
// - bits 9-0 read zero, 1 KB steps
// - reset clears user data base to zero
// - ram size register is read-only constant
// - flash base bits 31-20 read zero
// - flash base field 19-11 read/write, reset zero
// - flash base bits 10-0 read zero, 2 KB steps
package rfp_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [3:0] RFP_OFS_USER_DATA_BASE = 4'h0;
    localparam logic [3:0] RFP_OFS_RAM_SIZE = 4'h4;
    localparam logic [3:0] RFP_OFS_USER_PROG_BASE = 4'h8;
    localparam logic [3:0] RFP_OFS_PART_STATUS = 4'hc;

    // ****************************************
    // field layout and reset values
    // ****************************************
    localparam int RFP_UDB_LSB = 10;
    localparam int RFP_UDB_W = 6;
    localparam int RFP_UPB_LSB = 11;
    localparam int RFP_UPB_W = 9;
    localparam logic [RFP_UDB_W-1:0] RFP_UDB_RESET = 6'h00;
    localparam logic [RFP_UPB_W-1:0] RFP_UPB_RESET = 9'h000;
    localparam logic [31:0] RFP_RAM_SIZE_8K = 32'h0000_2000;
    localparam logic [31:0] RFP_ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rfp_req_s;
endpackage

// [dv/rfp_partition_regs_bench.sv]
/*
 * Self-checking bench for the partition register block.
 * Assumes the block answers reads one cycle after the strobe and never stalls.
 */
`timescale 1ns/10ps
module rfp_partition_regs_bench
    import rfp_pkg::*;
;
    logic clk, rst, ce, wr, rd, probe_user, probe_kernel;
    logic [3:0] addr;
    logic [31:0] wdata, probe_addr, rdata, user_data_base, user_prog_base;
    int fails = 0;
    int cmp_count = 0;

    rfp_partition_regs dut_u (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .probe_addr(probe_addr), .rdata(rdata),
        .user_data_base(user_data_base), .user_prog_base(user_prog_base),
        .probe_user(probe_user), .probe_kernel(probe_kernel));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // rdata is looked at only in the one cycle where it stands
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // write then read of one register on consecutive strobes, no idle cycle
    task automatic wr_rd_chk(input logic [3:0] a, input logic [31:0] d, input logic [31:0] exp);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic probe(input logic [31:0] p, input logic u, input logic k);
        @(posedge clk);
        probe_addr <= p;
        @(posedge clk);
        #1;
        chk({30'h0, probe_user, probe_kernel}, {30'h0, u, k});
    endtask

    task automatic wrap_up;
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_vals;
        rd_chk(RFP_OFS_USER_DATA_BASE, 32'h0000_0000);
        rd_chk(RFP_OFS_RAM_SIZE, 32'h0000_2000);
        rd_chk(RFP_OFS_USER_PROG_BASE, 32'h0000_0000);
        chk(user_data_base, 32'h0000_0000);
        probe(32'h0000_0000, 1'b0, 1'b1);
    endtask

    // base fields keep only their defined bits; the size word ignores writes
    task automatic t_fields;
        wr_reg(RFP_OFS_USER_DATA_BASE, 32'hffff_23ff);
        chk(user_data_base, 32'h0000_2000);
        rd_chk(RFP_OFS_USER_DATA_BASE, 32'h0000_2000);
        wr_rd_chk(RFP_OFS_USER_DATA_BASE, 32'h0000_1c00, 32'h0000_1c00);
        wr_rd_chk(RFP_OFS_USER_PROG_BASE, 32'hffff_ffff, 32'h000f_f800);
        chk(user_prog_base, 32'h000f_f800);
        rd_chk(RFP_OFS_USER_PROG_BASE, 32'h000f_f800);
        wr_reg(RFP_OFS_USER_PROG_BASE, 32'h0000_0fff);
        rd_chk(RFP_OFS_USER_PROG_BASE, 32'h0000_0800);
        wr_reg(RFP_OFS_RAM_SIZE, 32'h0000_0000);
        rd_chk(RFP_OFS_RAM_SIZE, 32'h0000_2000);
        rd_chk(4'h2, 32'h0000_0000);
    endtask

    // boundary at 1 KB: one byte below is kernel, the base itself user
    task automatic t_regions;
        wr_reg(RFP_OFS_USER_DATA_BASE, 32'h0000_07ff);
        chk(user_data_base, 32'h0000_0400);
        probe(32'h0000_03ff, 1'b0, 1'b1);
        probe(32'h0000_0400, 1'b1, 1'b0);
        rd_chk(RFP_OFS_PART_STATUS, 32'h0000_0002);
        probe(32'h0000_1fff, 1'b1, 1'b0);
        probe(32'h0000_2000, 1'b0, 1'b0);
    endtask

    // a write with the clock enable low must leave state untouched; reset still acts
    task automatic t_freeze_reset;
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(RFP_OFS_USER_DATA_BASE, 32'h0000_0000);
        chk(user_data_base, 32'h0000_0400);
        @(posedge clk);
        ce <= 1'b1;
        rd_chk(RFP_OFS_USER_DATA_BASE, 32'h0000_0400);
        @(posedge clk);
        rst <= 1'b1;
        ce <= 1'b0;
        @(posedge clk);
        rst <= 1'b0;
        ce <= 1'b1;
        #1;
        chk(user_data_base, 32'h0000_0000);
        chk(user_prog_base, 32'h0000_0000);
        chk(rdata, 32'h0000_0000);
        chk({30'h0, probe_user, probe_kernel}, 32'h0000_0000);
        rd_chk(RFP_OFS_USER_DATA_BASE, 32'h0000_0000);
    endtask

    // ****************************************
    // clock, reset, sequence and watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        probe_addr = 32'h0000_0000;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset_vals();
        t_fields();
        t_regions();
        t_freeze_reset();
        wrap_up();
    end

    initial begin
        #20000;
        fails++;
        wrap_up();
    end
endmodule

// [hw/rfp_partition_regs.sv]
/*
 * Partition registers: user data base, ram size and user program base,
 * plus a region check of one data ram address.
 * Every output is a flop or a fixed wiring of flop bits.
 * Assumes a master that issues one-cycle strobes, never both at once.
 */
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module rfp_partition_regs
    import rfp_pkg::*;
#(
    parameter logic [31:0] RAM_SIZE = RFP_RAM_SIZE_8K
) (
    input wire logic clk, // 100 MHz clock
    input wire logic rst, // synchronous reset, active high
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic [3:0] addr, // register byte address
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    input wire logic [31:0] probe_addr, // data ram address to classify
    output logic [31:0] rdata, // read data, one cycle after rd
    output logic [31:0] user_data_base, // user data boundary in bytes
    output logic [31:0] user_prog_base, // user program boundary in bytes
    output logic probe_user, // probe address is user data space
    output logic probe_kernel // probe address is kernel data space
);
    // ****************************************
    // request decode
    // ****************************************
    rfp_req_s req;
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    logic [RFP_UDB_W-1:0] udb_reg;
    logic [RFP_UPB_W-1:0] upb_reg;
    logic [31:0] rdata_reg;
    logic [1:0] probe_reg;

    function automatic logic [31:0] udb_word(input logic [RFP_UDB_W-1:0] f);
        udb_word = {16'h0000, f, 10'h000};
    endfunction

    function automatic logic [31:0] upb_word(input logic [RFP_UPB_W-1:0] f);
        upb_word = {12'h000, f, 11'h000};
    endfunction

    wire logic wr_udb = req.wr && (req.addr == RFP_OFS_USER_DATA_BASE);
    wire logic wr_upb = req.wr && (req.addr == RFP_OFS_USER_PROG_BASE);
    // low ten bits of the write are dropped so the boundary moves in 1 KB steps
    wire logic [RFP_UDB_W-1:0] udb_next = wr_udb ?
        req.wdata[RFP_UDB_LSB +: RFP_UDB_W] : udb_reg;
    wire logic [RFP_UPB_W-1:0] upb_next = wr_upb ?
        req.wdata[RFP_UPB_LSB +: RFP_UPB_W] : upb_reg;
    wire logic [31:0] udb_bytes = udb_word(udb_reg);
    wire logic [31:0] upb_bytes = upb_word(upb_reg);

    // ****************************************
    // region classification
    // ****************************************
    // registered so the status word and the probe outputs always agree
    logic chk_user;
    logic chk_kernel;
    rfp_region_check u_check (
        .addr(probe_addr),
        .user_base(udb_bytes),
        .ram_size(RAM_SIZE),
        .is_user(chk_user),
        .is_kernel(chk_kernel),
        .out_range()
    );

    // status word: current probe result, no write effect
    wire logic [31:0] status_word = {30'h0000_0000, probe_reg};
    wire logic [31:0] rd_mux =
        (req.addr == RFP_OFS_USER_DATA_BASE) ? udb_bytes :
        (req.addr == RFP_OFS_RAM_SIZE) ? RAM_SIZE :
        (req.addr == RFP_OFS_USER_PROG_BASE) ? upb_bytes :
        (req.addr == RFP_OFS_PART_STATUS) ? status_word : RFP_ZERO_WORD;
    // data is held for the one cycle after the strobe only
    wire logic [31:0] rdata_next = req.rd ? rd_mux : RFP_ZERO_WORD;

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            udb_reg <= RFP_UDB_RESET;
            upb_reg <= RFP_UPB_RESET;
            rdata_reg <= RFP_ZERO_WORD;
            probe_reg <= 2'h0;
        end else if (ce) begin
            udb_reg <= udb_next;
            upb_reg <= upb_next;
            rdata_reg <= rdata_next;
            probe_reg <= {chk_user, chk_kernel};
        end
    end

    assign rdata = rdata_reg;
    assign probe_user = probe_reg[1];
    assign probe_kernel = probe_reg[0];
    assign user_data_base = udb_bytes;
    assign user_prog_base = upb_bytes;

    // ****************************************
    // assertions
    // ****************************************
    property p_udb_high_zero;
        @(posedge clk) disable iff (rst) user_data_base[31:16] == 16'h0000;
    endproperty
    a_udb_high_zero: assert property (p_udb_high_zero) else $error("udb high bits set");

    property p_udb_write;
        @(posedge clk) disable iff (rst) (ce && wr && addr == RFP_OFS_USER_DATA_BASE)
            |=> user_data_base[15:10] == $past(wdata[15:10]);
    endproperty
    a_udb_write: assert property (p_udb_write) else $error("udb write lost");

    property p_udb_low_zero;
        @(posedge clk) disable iff (rst) user_data_base[9:0] == 10'h000;
    endproperty
    a_udb_low_zero: assert property (p_udb_low_zero) else $error("udb low bits set");

    property p_reset_clear;
        @(posedge clk) rst |=> (user_data_base == 32'h0 && user_prog_base == 32'h0);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left base");

    property p_size_read;
        @(posedge clk) disable iff (rst) (ce && rd && addr == RFP_OFS_RAM_SIZE)
            |=> rdata == RAM_SIZE;
    endproperty
    a_size_read: assert property (p_size_read) else $error("size read wrong");

    property p_upb_high_zero;
        @(posedge clk) disable iff (rst) user_prog_base[31:20] == 12'h000;
    endproperty
    a_upb_high_zero: assert property (p_upb_high_zero) else $error("upb high bits set");

    sequence s_upb_wr;
        ce && wr && addr == RFP_OFS_USER_PROG_BASE;
    endsequence
    property p_upb_write;
        @(posedge clk) disable iff (rst) s_upb_wr ##1 (ce && rd && addr == RFP_OFS_USER_PROG_BASE)
            |=> rdata[19:11] == $past(wdata[19:11], 2);
    endproperty
    a_upb_write: assert property (p_upb_write) else $error("upb readback wrong");

    property p_upb_low_zero;
        @(posedge clk) disable iff (rst) user_prog_base[10:0] == 11'h000;
    endproperty
    a_upb_low_zero: assert property (p_upb_low_zero) else $error("upb low bits set");

    // the probe flops capture address and base together, so the check takes
    // both one cycle back; a base written in that cycle must not leak in
    property p_region;
        @(posedge clk) disable iff (rst) (ce && !rst) |=> !(probe_user && probe_kernel)
            && (probe_user == ($past(probe_addr) < RAM_SIZE && $past(user_data_base) != 32'h0
            && $past(probe_addr) >= $past(user_data_base)));
    endproperty
    a_region: assert property (p_region) else $error("region wrong");

    property p_region_kernel;
        @(posedge clk) disable iff (rst) (ce && !rst) |=> probe_kernel ==
            ($past(probe_addr) < RAM_SIZE && ($past(user_data_base) == 32'h0
            || $past(probe_addr) < $past(user_data_base)));
    endproperty
    a_region_kernel: assert property (p_region_kernel) else $error("kernel wrong");

    // ****************************************
    // read port and clock enable
    // ****************************************
    // rdata is a pulse: software that polls it late must see zero, not stale data
    property p_rdata_idle;
        @(posedge clk) disable iff (rst) (ce && !rst && !rd) |=> rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not cleared");

    property p_udb_read;
        @(posedge clk) disable iff (rst) (ce && !rst && rd && addr == RFP_OFS_USER_DATA_BASE)
            |=> rdata[31:16] == 16'h0000 && rdata[9:0] == 10'h000
            && rdata[15:10] == $past(user_data_base[15:10]);
    endproperty
    a_udb_read: assert property (p_udb_read) else $error("udb read wrong");

    sequence s_udb_wr;
        ce && !rst && wr && addr == RFP_OFS_USER_DATA_BASE;
    endsequence
    property p_udb_readback;
        @(posedge clk) disable iff (rst) s_udb_wr ##1 (ce && rd && addr == RFP_OFS_USER_DATA_BASE)
            |=> rdata[15:10] == $past(wdata[15:10], 2);
    endproperty
    a_udb_readback: assert property (p_udb_readback) else $error("udb readback wrong");

    property p_upb_direct;
        @(posedge clk) disable iff (rst) (ce && !rst && wr && addr == RFP_OFS_USER_PROG_BASE)
            |=> user_prog_base[19:11] == $past(wdata[19:11]);
    endproperty
    a_upb_direct: assert property (p_upb_direct) else $error("upb write lost");

    // the size word and the status word take no write; a stray write must not
    // land in either base register
    property p_ro_write;
        @(posedge clk) disable iff (rst) (ce && !rst && wr && addr != RFP_OFS_USER_DATA_BASE
            && addr != RFP_OFS_USER_PROG_BASE) |=> $stable(user_data_base)
            && $stable(user_prog_base);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write landed");

    property p_status_read;
        @(posedge clk) disable iff (rst) (ce && !rst && rd && addr == RFP_OFS_PART_STATUS)
            |=> rdata == {30'h0000_0000, $past(probe_user), $past(probe_kernel)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    // a low enable holds every flop, the read pulse included, so a stalled
    // master finds its data still waiting
    property p_freeze;
        @(posedge clk) disable iff (rst) (!ce && !rst) |=> $stable(user_data_base)
            && $stable(user_prog_base) && $stable(rdata) && $stable(probe_user)
            && $stable(probe_kernel);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    property p_reset_outputs;
        @(posedge clk) rst |=> rdata == 32'h0 && !probe_user && !probe_kernel;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("reset left outputs");
endmodule

// [hw/rfp_region_check.sv]
/*
 * Classifies one data ram address as kernel, user or out of range.
 * Assumes the base and size inputs are stable register values.
 */
`timescale 1ns/10ps
module rfp_region_check
    import rfp_pkg::*;
(
    input wire logic [31:0] addr, // byte offset into data ram
    input wire logic [31:0] user_base, // user data base, byte address
    input wire logic [31:0] ram_size, // ram size in bytes
    output logic is_user, // address in user data space
    output logic is_kernel, // address in kernel data space
    output logic out_range // address beyond ram
);
    wire logic in_ram = addr < ram_size;
    // a zero base leaves all of ram to the kernel
    wire logic above_base = (user_base != RFP_ZERO_WORD) && (addr >= user_base);
    assign out_range = !in_ram;
    assign is_user = in_ram && above_base;
    assign is_kernel = in_ram && !above_base;
endmodule
